// ---- hw/pto_pkg.sv ----
package pto_pkg;
   // ------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam int IDX_W = 8;
   localparam logic [IDX_W-1:0] IDX_MODE = 8'ha0;
   localparam logic [IDX_W-1:0] IDX_TRIG_SEL = 8'ha1;
   localparam logic [IDX_W-1:0] IDX_HIGH_EN = 8'ha2;
   localparam logic [IDX_W-1:0] IDX_LOW_EN = 8'ha3;
   localparam int IDX_LSB = 2;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int GROUPS = 4;
   localparam int GRP_BITS = 4;
   localparam int SEL_W = 2;
   localparam int GRP0_SEL_LSB = 0;
   localparam int GRP1_SEL_LSB = 2;
   localparam int GRP2_SEL_LSB = 4;
   localparam int GRP3_SEL_LSB = 6;
   localparam logic [7:0] LOW_EN_RST = 8'h00;
   localparam logic [7:0] HIGH_EN_RST = 8'h00;
   localparam logic [7:0] TRIG_SEL_RST = 8'hff;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [3:0] MODE_RSVD_RD = 4'hf;
   localparam logic [15:0] PINS_RST = 16'h0000;

   // ------------------------------------------------------------
   // bus request carrier
   // ------------------------------------------------------------
   localparam int ADDR_W = 10;
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } pto_avl_req_t;

   typedef struct packed {
      logic [7:0] en_lo;
      logic [7:0] en_hi;
      logic [3:0] nov;
      logic [7:0] trig_sel;
      logic [15:0] pins;
      logic ack;
      logic [31:0] rdata;
   } pto_state_t;
endpackage

// ---- hw/pto_group.sv ----
`timescale 1ns/10ps
// next pin values for one 4-bit output group
module pto_group
(
   input wire logic trig_a,
   input wire logic trig_b,
   input wire logic nov,
   input wire logic [pto_pkg::GRP_BITS-1:0] staged,
   input wire logic [pto_pkg::GRP_BITS-1:0] en,
   input wire logic [pto_pkg::GRP_BITS-1:0] cur,
   output logic [pto_pkg::GRP_BITS-1:0] nxt
);
   import pto_pkg::*;

   always_comb
   begin
      nxt = cur;
      if (!nov)
      begin
         // normal: enabled bits copy staged data at match a
         if (trig_a)
            nxt = (staged & en) | (cur & ~en);
      end
      else
      begin
         // non-overlap: falling edges at match a, rising edges at match b
         if (trig_a)
            nxt = nxt & ~(en & ~staged);
         if (trig_b)
            nxt = nxt | (en & staged);
      end
   end
endmodule // pto_group

// ---- hw/pto_top.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Behaviour
// - bits 3:2 of trigger select pick timer channel for group 1
// - bits 5:4 of trigger select pick timer channel for group 2
// - bits 7:6 of trigger select pick timer channel for group 3
// - outputs 15..8 copy staged bit to port b only when enabled
// - outputs 7..0 copy staged bit to port a only when enabled
// - both enable registers reset to zero and are read/write
// - bits 1:0 of trigger select pick timer channel for group 0
// - non-overlap clear: group updates at selected compare match a
// - non-overlap set: group updates at selected compare match b
// ------------------------------------------------------------
module pto_top
   import pto_pkg::*;
#(
   parameter int CHANNELS = 4
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire pto_pkg::pto_avl_req_t avl_req,
   output logic [31:0] avl_readdata,
   output logic avl_waitrequest,
   input wire logic [CHANNELS-1:0] cmp_a,
   input wire logic [CHANNELS-1:0] cmp_b,
   input wire logic [15:0] next_data,
   output logic [7:0] port_a_pins,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_pins,
   output logic [7:0] port_b_oe
);
   import pto_pkg::*;

   if (CHANNELS != (1 << SEL_W))
   begin : g_bad_channels
      $error("pto_top: CHANNELS must equal four");
   end

   pto_state_t q;
   pto_state_t d;
   logic [IDX_W-1:0] idx;
   logic req;
   logic [GROUPS-1:0] trig_a_w;
   logic [GROUPS-1:0] trig_b_w;
   logic [15:0] en_all;
   logic [15:0] pins_nxt;

   assign idx = avl_req.address[IDX_LSB +: IDX_W];
   assign req = avl_req.read | avl_req.write;
   assign en_all = {q.en_hi, q.en_lo};

   // ------------------------------------------------------------
   // trigger routing and group update
   // ------------------------------------------------------------
   for (genvar g = 0; g < GROUPS; g++)
   begin : g_grp
      logic [SEL_W-1:0] sel;
      assign sel = q.trig_sel[g*SEL_W +: SEL_W];
      assign trig_a_w[g] = cmp_a[sel];
      assign trig_b_w[g] = cmp_b[sel];
      pto_group u_grp (
         .trig_a(trig_a_w[g]),
         .trig_b(trig_b_w[g]),
         .nov(q.nov[g]),
         .staged(next_data[g*GRP_BITS +: GRP_BITS]),
         .en(en_all[g*GRP_BITS +: GRP_BITS]),
         .cur(q.pins[g*GRP_BITS +: GRP_BITS]),
         .nxt(pins_nxt[g*GRP_BITS +: GRP_BITS])
      );
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.pins = pins_nxt;
      d.ack = req & ~q.ack;
      if (req && !q.ack)
      begin
         case (idx)
            IDX_MODE: d.rdata = {24'h000000, MODE_RSVD_RD, q.nov};
            IDX_TRIG_SEL: d.rdata = {24'h000000, q.trig_sel};
            IDX_HIGH_EN: d.rdata = {24'h000000, q.en_hi};
            IDX_LOW_EN: d.rdata = {24'h000000, q.en_lo};
            default: d.rdata = 32'h00000000;
         endcase
      end
      if (avl_req.write && q.ack && avl_req.byteenable[0])
      begin
         case (idx)
            IDX_MODE: d.nov = avl_req.writedata[3:0];
            IDX_TRIG_SEL: d.trig_sel = avl_req.writedata[7:0];
            IDX_HIGH_EN: d.en_hi = avl_req.writedata[7:0];
            IDX_LOW_EN: d.en_lo = avl_req.writedata[7:0];
            default: d = d;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         q.en_lo <= LOW_EN_RST;
         q.en_hi <= HIGH_EN_RST;
         q.nov <= MODE_RST;
         q.trig_sel <= TRIG_SEL_RST;
         q.pins <= PINS_RST;
         q.ack <= 1'b0;
         q.rdata <= 32'h00000000;
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign avl_waitrequest = req & ~q.ack;
   assign avl_readdata = q.rdata;
   assign port_a_pins = q.pins[7:0];
   assign port_b_pins = q.pins[15:8];
   assign port_a_oe = q.en_lo;
   assign port_b_oe = q.en_hi;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sel_grp0_a: assert property (@(posedge clock) disable iff (rst)
      (ce && !q.nov[0] && cmp_a[q.trig_sel[1:0]])
      |=> ((port_a_pins[3:0] & $past(port_a_oe[3:0]))
           == ($past(next_data[3:0]) & $past(port_a_oe[3:0]))))
      else $error("group 0 missed its selected trigger");

   sel_grp1_a: assert property (@(posedge clock) disable iff (rst)
      (ce && !q.nov[1] && cmp_a[q.trig_sel[3:2]])
      |=> ((port_a_pins[7:4] & $past(port_a_oe[7:4]))
           == ($past(next_data[7:4]) & $past(port_a_oe[7:4]))))
      else $error("group 1 missed its selected trigger");

   sel_grp2_a: assert property (@(posedge clock) disable iff (rst)
      (ce && !q.nov[2] && cmp_a[q.trig_sel[5:4]])
      |=> ((port_b_pins[3:0] & $past(port_b_oe[3:0]))
           == ($past(next_data[11:8]) & $past(port_b_oe[3:0]))))
      else $error("group 2 missed its selected trigger");

   sel_grp3_a: assert property (@(posedge clock) disable iff (rst)
      (ce && !q.nov[3] && cmp_a[q.trig_sel[7:6]])
      |=> ((port_b_pins[7:4] & $past(port_b_oe[7:4]))
           == ($past(next_data[15:12]) & $past(port_b_oe[7:4]))))
      else $error("group 3 missed its selected trigger");

   port_b_hold_a: assert property (@(posedge clock) disable iff (rst)
      1'b1 |=> ((port_b_pins & ~$past(port_b_oe))
                == ($past(port_b_pins) & ~$past(port_b_oe))))
      else $error("disabled port b bit changed");

   port_a_hold_a: assert property (@(posedge clock) disable iff (rst)
      1'b1 |=> ((port_a_pins & ~$past(port_a_oe))
                == ($past(port_a_pins) & ~$past(port_a_oe))))
      else $error("disabled port a bit changed");

   enable_reset_a: assert property (@(posedge clock)
      rst |=> (port_a_oe == 8'h00 && port_b_oe == 8'h00))
      else $error("enables not cleared by reset");

   normal_no_b_a: assert property (@(posedge clock) disable iff (rst)
      (ce && !q.nov[0] && !trig_a_w[0] && trig_b_w[0])
      |=> $stable(port_a_pins[3:0]))
      else $error("normal group moved on match b");

   nov_rise_b_a: assert property (@(posedge clock) disable iff (rst)
      (ce && q.nov[0] && !trig_a_w[0] && trig_b_w[0])
      |=> (((port_a_pins[3:0] & ~$past(port_a_pins[3:0])) & ~$past(next_data[3:0]))
           == 4'h0)
          && ((port_a_pins[3:0] & $past(port_a_oe[3:0]) & $past(next_data[3:0]))
              == ($past(port_a_oe[3:0]) & $past(next_data[3:0]))))
      else $error("non-overlap group wrong on match b");

   no_strobe_a: assert property (@(posedge clock) disable iff (rst)
      (!ce || (cmp_a == 4'h0 && cmp_b == 4'h0)) |=> $stable(q.pins))
      else $error("pins moved without a strobe");

   wait_one_a: assert property (@(posedge clock) disable iff (rst)
      (ce && req && avl_waitrequest) |=> (req -> !avl_waitrequest))
      else $error("bus answer later than one wait cycle");

   low_en_write_a: assert property (@(posedge clock) disable iff (rst)
      (ce && avl_req.write && !avl_waitrequest && avl_req.byteenable[0]
       && (idx == IDX_LOW_EN))
      |=> (port_a_oe == $past(avl_req.writedata[7:0])))
      else $error("low enable write lost");

   high_en_write_a: assert property (@(posedge clock) disable iff (rst)
      (ce && avl_req.write && !avl_waitrequest && avl_req.byteenable[0]
       && (idx == IDX_HIGH_EN))
      |=> (port_b_oe == $past(avl_req.writedata[7:0])))
      else $error("high enable write lost");

   refused_write_a: assert property (@(posedge clock) disable iff (rst)
      (ce && avl_req.write && !avl_waitrequest && !avl_req.byteenable[0])
      |=> ($stable(port_a_oe) && $stable(port_b_oe)))
      else $error("write without lane 0 changed an enable");

   en_readback_a: assert property (@(posedge clock) disable iff (rst)
      (ce && avl_req.read && avl_waitrequest && (idx == IDX_LOW_EN))
      |=> (avl_readdata == {24'h000000, $past(port_a_oe)}))
      else $error("low enable read back wrong");

   sel_readback_a: assert property (@(posedge clock) disable iff (rst)
      (ce && avl_req.read && avl_waitrequest && (idx == IDX_TRIG_SEL))
      |=> (avl_readdata == {24'h000000, $past(q.trig_sel)}))
      else $error("trigger select read back wrong");

   grp3_nov_clear_a: assert property (@(posedge clock) disable iff (rst)
      (ce && q.nov[3] && trig_a_w[3] && !trig_b_w[3])
      |=> (((port_b_pins[7:4] & ~$past(port_b_pins[7:4])) == 4'h0)
           && ((port_b_pins[7:4] & $past(port_b_oe[7:4]) & ~$past(next_data[15:12]))
               == 4'h0)))
      else $error("non-overlap group 3 wrong on match a");

   grp0_idle_a: assert property (@(posedge clock) disable iff (rst)
      (ce && !trig_a_w[0] && !trig_b_w[0]) |=> $stable(port_a_pins[3:0]))
      else $error("group 0 moved without its trigger");
endmodule // pto_top

// ---- sim/pto_timer_model.sv ----
`timescale 1ns/10ps
// timer side: each request becomes a one-cycle compare-match strobe
module pto_timer_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] req_a,
   input wire logic [3:0] req_b,
   output logic [3:0] cmp_a,
   output logic [3:0] cmp_b
);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cmp_a <= 4'h0;
         cmp_b <= 4'h0;
      end
      else
      begin
         cmp_a <= req_a & ~cmp_a;
         cmp_b <= req_b & ~cmp_b;
      end
   end
endmodule // pto_timer_model

// ---- sim/test_pulse_output_trigger_enable.sv ----
`timescale 1ns/10ps
module test_pulse_output_trigger_enable;
   import pto_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   pto_avl_req_t avl_req = '0;
   logic [31:0] avl_readdata, seed = 32'd74149;
   logic avl_waitrequest, chk = 1'b0, ce = 1'b1;
   logic [3:0] req_a = 4'h0, req_b = 4'h0, cmp_a, cmp_b, nov = 4'h0;
   logic [15:0] next_data = 16'h0, pins_e = 16'h0;
   logic [7:0] pa, pao, pb, pbo, en_lo = 8'h0, en_hi = 8'h0, sel = 8'hff;
   logic [31:0] exp_q[$];
   int n_fail = 0;
   int check_count = 0;
   always #10 clock = ~clock;
   pto_timer_model pto_timer_model_i (.clock(clock), .rst(rst), .req_a(req_a),
      .req_b(req_b), .cmp_a(cmp_a), .cmp_b(cmp_b));
   pto_top pto_top_i (.clock(clock), .rst(rst), .ce(ce), .avl_req(avl_req),
      .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest), .cmp_a(cmp_a),
      .cmp_b(cmp_b), .next_data(next_data), .port_a_pins(pa), .port_a_oe(pao),
      .port_b_pins(pb), .port_b_oe(pbo));
   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clock)
   begin
      if (avl_req.read && avl_waitrequest === 1'b0)
         check(avl_readdata, exp_q.pop_front());
      if (chk)
         check({pbo, pao, pb, pa}, exp_q.pop_front());
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] be);
      int k;
      @(posedge clock);
      avl_req <= '{read: ~wr, write: wr, address: {idx, 2'b00}, writedata: {24'h0, d},
                   byteenable: be};
      for (k = 0; k < 20; k++)
      begin
         @(posedge clock);
         if (avl_waitrequest === 1'b0)
            break;
      end
      if (k == 20)
      begin
         n_fail++;
         complete_run();
      end
      avl_req <= '0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] want);
      exp_q.push_back(want);
      bus(1'b0, idx, 8'h00, 4'hf);
   endtask
   task automatic setup(input logic [7:0] s, input logic [7:0] lo, input logic [7:0] hi,
                        input logic [3:0] nv);
      sel = s;
      en_lo = lo;
      en_hi = hi;
      nov = nv;
      bus(1'b1, IDX_TRIG_SEL, s, 4'h1);
      bus(1'b1, IDX_LOW_EN, lo, 4'h1);
      bus(1'b1, IDX_HIGH_EN, hi, 4'h1);
      bus(1'b1, IDX_MODE, {4'h0, nv}, 4'h1);
      rd(IDX_LOW_EN, {24'h0, lo});
      rd(IDX_HIGH_EN, {24'h0, hi});
      rd(IDX_TRIG_SEL, {24'h0, s});
      rd(IDX_MODE, {24'h0, 4'hf, nv});
   endtask
   task automatic fire(input logic [3:0] a, input logic [3:0] b);
      logic [15:0] nd, m;
      int g;
      nd = rnd();
      @(posedge clock);
      req_a <= a;
      req_b <= b;
      next_data <= nd;
      @(posedge clock);
      req_a <= 4'h0;
      req_b <= 4'h0;
      for (g = 0; ce && g < 4; g++)
      begin
         m = {en_hi, en_lo} & (16'hf << (4 * g));
         if (a[sel[2*g +: 2]])
            pins_e = nov[g] ? pins_e & ~(m & ~nd) : (pins_e & ~m) | (nd & m);
         if (nov[g] && b[sel[2*g +: 2]])
            pins_e = pins_e | (m & nd);
      end
      @(posedge clock);
      exp_q.push_back({en_hi, en_lo, pins_e});
      chk <= 1'b1;
      @(posedge clock);
      chk <= 1'b0;
   endtask
   initial
   begin
      int i;
      logic [31:0] r;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd(IDX_LOW_EN, 32'h0);
      rd(IDX_HIGH_EN, 32'h0);
      rd(IDX_TRIG_SEL, 32'hff);
      rd(IDX_MODE, 32'hf0);
      rd(8'h10, 32'h0);
      bus(1'b1, IDX_LOW_EN, 8'h5a, 4'h0);
      rd(IDX_LOW_EN, 32'h0);
      $display("test reset_and_refusals done");
      for (i = 0; i < 4; i++)
      begin
         setup({4{i[1:0]}}, 8'hff, 8'hff, 4'h0);
         fire(~(4'h1 << i), 4'hf);
         fire(4'h1 << i, 4'h0);
      end
      $display("test select_codes done");
      for (i = 0; i < 40; i++)
      begin
         r = rnd();
         setup(r[7:0], r[15:8], r[23:16], r[27:24]);
         r = rnd();
         fire(r[3:0], r[7:4]);
      end
      $display("test random_triggers done");
      setup(8'h00, 8'hff, 8'hff, 4'h0);
      @(posedge clock);
      ce <= 1'b0;
      fire(4'hf, 4'hf);
      ce <= 1'b1;
      fire(4'h1, 4'h0);
      $display("test clock_enable done");
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      sel = 8'hff;
      nov = 4'h0;
      en_lo = 8'h00;
      en_hi = 8'h00;
      pins_e = 16'h0000;
      rd(IDX_LOW_EN, 32'h0);
      rd(IDX_HIGH_EN, 32'h0);
      rd(IDX_TRIG_SEL, 32'hff);
      fire(4'hf, 4'hf);
      $display("test midrun_reset done");
      repeat (2) @(posedge clock);
      complete_run();
   end
endmodule // test_pulse_output_trigger_enable
